// ### cdac_top.sv
`timescale 1ns/1ns
`default_nettype none
module cdac_top
   import cdac_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Analog comparator core.
   input wire logic raw_comparator_output,
   output logic comparator_enable,
   output logic comparator_hyst,
   output cdac_route_s input_route,
   output logic [PIN_EN_W-1:0] input_pin_enable_bits,
   // DAC core.
   output cdac_dac_s dac_cfg,
   // Comparator output pad.
   output logic cmp_pin_out,
   output logic cmp_pin_oe,
   // Power state.
   input wire logic low_power_stop_state,
   // CPU interrupts.
   output logic cmp_irq,
   output logic wake_irq
);

   // ==========================================================
   // Register storage.
   cdac_status_s status;
   logic [7:0] insel;
   cdac_dac_s dac_reg;
   logic [PIN_EN_W-1:0] pin_en;

   // Stored status fields; the readable view is put together below.
   logic st_ena;
   logic st_hyst;
   logic st_flag;
   logic st_ie;
   logic st_ope;
   logic [1:0] st_mode;

   logic cmp_sync;
   logic output_status_bit;
   logic edge_pulse;
   logic wr_status;
   logic wr_insel;
   logic wr_dac;
   logic wr_pinen;
   logic flag_clear;
   logic next_flag;
   logic [7:0] next_rdata;

   // Write strobes are decoded from the exact byte address.
   assign wr_status = reg_wr && (reg_addr == ADDR_STATUS);
   assign wr_insel = reg_wr && (reg_addr == ADDR_INSEL);
   assign wr_dac = reg_wr && (reg_addr == ADDR_DAC);
   assign wr_pinen = reg_wr && (reg_addr == ADDR_PINEN);

   // ==========================================================
   // Comparator output synchronisation and edge detection.
   cdac_sync #(
      .WIDTH(1)
   ) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(raw_comparator_output),
      .sync_out(cmp_sync)
   );

   // The edge detector keeps its history frozen in the stop state; edges
   // that arrive then are caught by the wake logic further down only with ena and ie set and the edge matching the mode.
   cdac_edge u_edge (
      .core_clk(core_clk),
      .rst(rst),
      .enable(status.ena),
      .hold(low_power_stop_state),
      .mode(status.mode),
      .sample(cmp_sync),
      .level(output_status_bit),
      .edge_pulse(edge_pulse)
   );

   // ==========================================================
   // Status and control register.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_ena <= STATUS_RESET[STAT_ENA_POS];
         st_hyst <= STATUS_RESET[STAT_HYST_POS];
         st_ie <= STATUS_RESET[STAT_IE_POS];
         st_ope <= STATUS_RESET[STAT_OPE_POS];
         st_mode <= STATUS_RESET[STAT_MODE_POS +: 2];
      end else if (wr_status) begin
         st_ena <= reg_wdata[STAT_ENA_POS];
         st_hyst <= reg_wdata[STAT_HYST_POS];
         st_ie <= reg_wdata[STAT_IE_POS];
         st_ope <= reg_wdata[STAT_OPE_POS];
         st_mode <= reg_wdata[STAT_MODE_POS +: 2];
      end
   end

   // The output bit is the synchronised comparator level, masked so
   // that it reads zero as soon as the comparator enable is cleared.
   always_comb begin
      status.ena = st_ena;
      status.hyst = st_hyst;
      status.flag = st_flag;
      status.ie = st_ie;
      status.out = output_status_bit & st_ena;
      status.ope = st_ope;
      status.mode = st_mode;
   end

   // ==========================================================
   // Sticky event flag: only a zero write clears it, and a new
   // edge in the same cycle wins over the clear.
   assign flag_clear = wr_status && !reg_wdata[STAT_FLAG_POS];

   always_comb begin
      next_flag = status.flag;
      if (flag_clear) begin
         next_flag = 1'b0;
      end
      if (edge_pulse) begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_flag <= STATUS_RESET[STAT_FLAG_POS];
      end else begin
         st_flag <= next_flag;
      end
   end

   // ==========================================================
   // Input select register; reserved bits are not stored.
   // Changing a select while enabled is passed on a cycle later, so
   // software keeps the selects still while the comparator runs.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         insel <= INSEL_RESET;
      end else if (wr_insel) begin
         insel <= '0;
         insel[INSEL_POS_POS +: 2] <= reg_wdata[INSEL_POS_POS +: 2];
         insel[INSEL_NEG_POS +: 2] <= reg_wdata[INSEL_NEG_POS +: 2];
      end
   end

   // ==========================================================
   // DAC control register.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dac_reg <= cdac_dac_s'(DAC_RESET);
      end else if (wr_dac) begin
         dac_reg.en <= reg_wdata[DAC_EN_POS];
         dac_reg.ref_sel <= reg_wdata[DAC_REF_POS];
         dac_reg.code <= reg_wdata[DAC_CODE_POS +: DAC_CODE_W];
      end
   end

   // ==========================================================
   // Input pin enable register.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_en <= PINEN_RESET[PIN_EN_W-1:0];
      end else if (wr_pinen) begin
         pin_en <= reg_wdata[PIN_EN_W-1:0];
      end
   end

   // ==========================================================
   // Route decode: one-hot of external 0, external 1 and DAC.
   function automatic logic [2:0] route_of(input logic [1:0] sel);
      case (cdac_sel_e'(sel))
         SEL_EXT0: route_of = 3'h1;
         SEL_EXT1: route_of = 3'h2;
         SEL_DAC: route_of = 3'h4;
         default: route_of = 3'h0;
      endcase
   endfunction

   // ==========================================================
   // Analog core drive, all from flip-flops.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         comparator_enable <= 1'b0;
         comparator_hyst <= 1'b0;
         input_route <= '0;
         input_pin_enable_bits <= '0;
      end else begin
         comparator_enable <= status.ena;
         comparator_hyst <= status.hyst;
         input_route.pos_select <= insel[INSEL_POS_POS +: 2];
         input_route.neg_select <= insel[INSEL_NEG_POS +: 2];
         input_route.pos_route <= route_of(insel[INSEL_POS_POS +: 2]);
         input_route.neg_route <= route_of(insel[INSEL_NEG_POS +: 2]);
         input_pin_enable_bits <= pin_en;
      end
   end

   // The DAC level only leaves the block while the DAC is enabled.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dac_cfg <= cdac_dac_s'(DAC_RESET);
      end else begin
         dac_cfg.en <= dac_reg.en;
         dac_cfg.ref_sel <= dac_reg.ref_sel;
         dac_cfg.code <= dac_reg.en ? dac_reg.code : '0;
      end
   end

   // ==========================================================
   // Output pad: driven only with the output pin enable set.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmp_pin_out <= 1'b0;
         cmp_pin_oe <= 1'b0;
      end else begin
         cmp_pin_oe <= status.ope;
         cmp_pin_out <= status.ope & output_status_bit;
      end
   end

   // ==========================================================
   // CPU interrupt request.
   // It follows the next flag value gated by ie, so with ie set it rises with the flag and
   // drops with the flag, in the cycle after the clearing write.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmp_irq <= 1'b0;
      end else begin
         cmp_irq <= next_flag & status.ie;
      end
   end

   // ==========================================================
   // Stop-state wake: the comparator output itself clocks two
   // catch flip-flops, since the bus clock is absent. They clear
   // as soon as the stop state ends; the synchronised path has
   // taken over by then.
   logic wake_clear;
   logic wake_rise;
   logic wake_fall;
   logic rise_ok;
   logic fall_ok;

   assign wake_clear = rst | ~low_power_stop_state;
   assign rise_ok = (status.mode == EDGE_RISE) ||
                    (status.mode == EDGE_BOTH);
   assign fall_ok = (status.mode != EDGE_RISE);

   always_ff @(posedge raw_comparator_output or posedge wake_clear) begin
      if (wake_clear) begin
         wake_rise <= 1'b0;
      end else begin
         wake_rise <= status.ena & status.ie & rise_ok;
      end
   end

   always_ff @(negedge raw_comparator_output or posedge wake_clear) begin
      if (wake_clear) begin
         wake_fall <= 1'b0;
      end else begin
         wake_fall <= status.ena & status.ie & fall_ok;
      end
   end

   // The wake line is a gate of two catch flops, not a bus clock flop,
   // because no bus clock edge exists in the stop state to launch it.
   assign wake_irq = wake_rise | wake_fall;

   // ==========================================================
   // Register read: data stand in the cycle after the strobe only.
   // Unmapped addresses and reserved bits read as zero.
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         ADDR_STATUS: next_rdata = status;
         ADDR_INSEL: next_rdata = insel;
         ADDR_DAC: next_rdata = dac_reg;
         ADDR_PINEN: next_rdata = {5'h00, pin_en};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
      end
   end

endmodule
`default_nettype wire

// ### cdac_pkg.sv
package cdac_pkg;

   // ==========================================================
   // Register offsets.
   localparam logic [7:0] ADDR_STATUS = 8'h2c;
   localparam logic [7:0] ADDR_INSEL = 8'h2d;
   localparam logic [7:0] ADDR_DAC = 8'h2e;
   localparam logic [7:0] ADDR_PINEN = 8'h2f;

   // ==========================================================
   // Reset values.
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] INSEL_RESET = 8'h00;
   localparam logic [7:0] DAC_RESET = 8'h00;
   localparam logic [7:0] PINEN_RESET = 8'h00;

   // ==========================================================
   // Field positions and widths.
   localparam int STAT_ENA_POS = 7;
   localparam int STAT_HYST_POS = 6;
   localparam int STAT_FLAG_POS = 5;
   localparam int STAT_IE_POS = 4;
   localparam int STAT_OUT_POS = 3;
   localparam int STAT_OPE_POS = 2;
   localparam int STAT_MODE_POS = 0;
   localparam int INSEL_POS_POS = 4;
   localparam int INSEL_NEG_POS = 0;
   localparam int DAC_EN_POS = 7;
   localparam int DAC_REF_POS = 6;
   localparam int DAC_CODE_POS = 0;
   localparam int DAC_CODE_W = 6;
   localparam int DAC_LEVELS = 64;
   localparam int PIN_EN_W = 3;
   localparam int SYNC_STAGES = 2;

   // ==========================================================
   // Encodings.
   typedef enum logic [1:0] {
      EDGE_FALL = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL_ALT = 2'h2,
      EDGE_BOTH = 2'h3
   } cdac_edge_e;

   typedef enum logic [1:0] {
      SEL_EXT0 = 2'h0,
      SEL_EXT1 = 2'h1,
      SEL_RSVD = 2'h2,
      SEL_DAC = 2'h3
   } cdac_sel_e;

   // ==========================================================
   // Register layouts.
   typedef struct packed {
      logic ena;
      logic hyst;
      logic flag;
      logic ie;
      logic out;
      logic ope;
      logic [1:0] mode;
   } cdac_status_s;

   typedef struct packed {
      logic en;
      logic ref_sel;
      logic [DAC_CODE_W-1:0] code;
   } cdac_dac_s;

   typedef struct packed {
      logic [2:0] pos_route;
      logic [2:0] neg_route;
      logic [1:0] pos_select;
      logic [1:0] neg_select;
   } cdac_route_s;

endpackage

// ### cdac_sync.sv
`timescale 1ns/1ns
`default_nettype none
module cdac_sync
   import cdac_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Asynchronous input and synchronised output.
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ==========================================================
   // Two-stage synchroniser; the first stage feeds only the second.
   logic [WIDTH-1:0] stage [SYNC_STAGES];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            stage[i] <= '0;
         end
      end else begin
         stage[0] <= async_in;
         for (int i = 1; i < SYNC_STAGES; i++) begin
            stage[i] <= stage[i-1];
         end
      end
   end

   assign sync_out = stage[SYNC_STAGES-1];

endmodule
`default_nettype wire

// ### cdac_edge.sv
`timescale 1ns/1ns
`default_nettype none
module cdac_edge
   import cdac_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Control.
   input wire logic enable,
   input wire logic hold,
   input wire logic [1:0] mode,
   // Synchronised comparator sample.
   input wire logic sample,
   // Results.
   output logic level,
   output logic edge_pulse
);

   logic prev;
   logic armed;
   logic rise;
   logic fall;
   logic accept;

   assign rise = sample & ~prev;
   assign fall = ~sample & prev;

   // ==========================================================
   // Mode decode.
   always_comb begin
      case (cdac_edge_e'(mode))
         EDGE_RISE: accept = rise;
         EDGE_BOTH: accept = rise | fall;
         EDGE_FALL, EDGE_FALL_ALT: accept = fall;
         default: accept = 1'b0;
      endcase
   end

   // ==========================================================
   // Sample history; held while the clock is about to stop.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prev <= 1'b0;
         armed <= 1'b0;
         level <= 1'b0;
      end else if (!hold) begin
         prev <= sample;
         armed <= enable;
         level <= enable & sample;
      end
   end

   // A qualifying transition is flagged only once the enable has
   // settled for a cycle; a rise of the core output on switching on arrives later via the synchroniser and is flagged like any rise.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         edge_pulse <= 1'b0;
      end else begin
         edge_pulse <= enable & armed & ~hold & accept;
      end
   end

endmodule
`default_nettype wire

// ### cdac_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module cdac_chk
   import cdac_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   // Core, pads and interrupts.
   input wire logic raw_comparator_output,
   input wire logic comparator_enable,
   input wire cdac_route_s input_route,
   input wire logic [PIN_EN_W-1:0] input_pin_enable_bits,
   input wire cdac_dac_s dac_cfg,
   input wire logic cmp_pin_out,
   input wire logic low_power_stop_state,
   input wire logic cmp_irq,
   input wire logic wake_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // ====================
   // Expected decodes.
   function automatic logic [7:0] dac_of(input logic [7:0] x);
      return {x[7:6], x[7] ? x[5:0] : 6'h00};
   endfunction
   function automatic logic [2:0] route_of(input logic [1:0] s);
      return (s == SEL_DAC) ? 3'h4 :
             (s == SEL_RSVD) ? 3'h0 : 3'(s) + 3'h1;
   endfunction

   // ====================
   // Properties.
   sequence s_wr(logic [7:0] a);
      reg_wr && reg_addr == a;
   endsequence
   sequence s_quiet;
      (!reg_wr && !low_power_stop_state &&
       $stable(raw_comparator_output)) [*8];
   endsequence
   property p_dac_wr;
      s_wr(ADDR_DAC) |=> ##1 dac_cfg == dac_of($past(reg_wdata, 2));
   endproperty
   a_dac_wr: assert property (p_dac_wr)
      else $error("dac config does not follow the write");
   property p_dac_off; !dac_cfg.en |-> dac_cfg.code == 6'h00; endproperty
   a_dac_off: assert property (p_dac_off)
      else $error("disabled dac shows a code");
   property p_pin_en;
      s_wr(ADDR_PINEN) |=> ##1
         {5'h00, input_pin_enable_bits} == ($past(reg_wdata, 2) & 8'h07);
   endproperty
   a_pin_en: assert property (p_pin_en)
      else $error("pin enables do not follow the write");
   property p_route;
      !$past(rst) |->
      input_route.pos_route == route_of(input_route.pos_select) &&
      input_route.neg_route == route_of(input_route.neg_select);
   endproperty
   a_route: assert property (p_route)
      else $error("input route does not match select");
   property p_quiet; s_quiet |=> !$rose(cmp_irq); endproperty
   a_quiet: assert property (p_quiet)
      else $error("interrupt without an output edge");
   property p_clear;
      $fell(cmp_irq) |-> $past(reg_wr) && $past(reg_addr) == ADDR_STATUS;
   endproperty
   a_clear: assert property (p_clear)
      else $error("interrupt dropped without a status write");
   property p_one;
      reg_wr && reg_addr == ADDR_STATUS && reg_wdata[5:4] == 2'h3 &&
      cmp_irq |=> cmp_irq;
   endproperty
   a_one: assert property (p_one)
      else $error("writing one cleared the flag");
   property p_off; !comparator_enable [*3] |-> !cmp_pin_out; endproperty
   a_off: assert property (p_off)
      else $error("output seen while comparator disabled");
   property p_stop;
      (low_power_stop_state && !reg_wr) [*3] |-> $stable(cmp_pin_out);
   endproperty
   a_stop: assert property (p_stop)
      else $error("output moved in stop state");
   property p_wake; wake_irq |-> low_power_stop_state; endproperty
   a_wake: assert property (p_wake)
      else $error("wake raised outside stop state");
endmodule

bind cdac_top cdac_chk u_chk (.core_clk, .rst, .reg_addr, .reg_wdata,
   .reg_wr, .raw_comparator_output, .comparator_enable, .input_route,
   .input_pin_enable_bits, .dac_cfg, .cmp_pin_out, .low_power_stop_state,
   .cmp_irq, .wake_irq);
`default_nettype wire

// ### cdac_cmp_model.sv
`timescale 1ns/1ns
`default_nettype none
module cdac_cmp_model (
   // Enable from the block.
   input wire logic enable,
   // Analog decision and settling speed.
   input wire logic level,
   input wire logic slow,
   // Raw decision to the block.
   output logic raw
);
   // A disabled core decides low; settling is unrelated to the clock.
   always @(enable or level or slow) begin
      raw <= #(slow ? 33 : 2) enable & level;
   end
endmodule
`default_nettype wire

// ### tb_comparator_dac_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_comparator_dac_control
   import cdac_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic low_power_stop_state = 1'b0;
   logic level = 1'b0;
   logic slow = 1'b0;
   logic [7:0] reg_rdata;
   logic [7:0] v;
   logic raw_comparator_output, comparator_enable, comparator_hyst;
   logic cmp_pin_out, cmp_pin_oe, cmp_irq, wake_irq;
   logic [PIN_EN_W-1:0] input_pin_enable_bits;
   cdac_route_s input_route;
   cdac_dac_s dac_cfg;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;

   always #10 core_clk = ~core_clk;

   cdac_cmp_model model (.enable(comparator_enable), .level(level),
      .slow(slow), .raw(raw_comparator_output));

   cdac_top dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .raw_comparator_output, .comparator_enable,
      .comparator_hyst, .input_route, .input_pin_enable_bits, .dac_cfg,
      .cmp_pin_out, .cmp_pin_oe, .low_power_stop_state, .cmp_irq,
      .wake_irq);

   // ====================
   // Bus cycles and checks.
   task automatic chk(input logic [7:0] seen, exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, x);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= x;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic rchk(input logic [7:0] a, exp, input string what);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk(reg_rdata, exp, what);
   endtask
   task automatic edge_to(input logic l);
      @(posedge core_clk);
      level <= l;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   function automatic logic hit(input logic [1:0] m, input logic rise);
      return m == EDGE_BOTH || (m == EDGE_RISE) == rise;
   endfunction
   function automatic logic [7:0] dac_exp(input logic [7:0] x);
      return {x[7:6], x[7] ? x[5:0] : 6'h00};
   endfunction
   task automatic test_done;
      if (n_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_errors++;
         test_done();
      end
   end

   // ====================
   // Scenarios.
   initial begin
      void'($urandom(32'haf72));
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      wr(8'h31, 8'hff);
      for (int a = 0; a < 6; a++) begin
         rchk(ADDR_STATUS + 8'(a), 8'h00, "reset");
      end
      chk(dac_cfg, 8'h00, "dac_cfg");
      chk(8'({comparator_enable, comparator_hyst}), 8'h00, "core_rst");
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'hff : (i == 1) ? 8'h80 : 8'($urandom);
         wr(ADDR_DAC, v & 8'h7f);
         wr(ADDR_DAC, v);
         rchk(ADDR_DAC, v, "dac_reg");
         chk(dac_cfg, dac_exp(v), "dac_cfg");
      end
      wr(ADDR_PINEN, 8'hff);
      rchk(ADDR_PINEN, 8'h07, "pin_en");
      chk(8'(input_pin_enable_bits), 8'h07, "pin_bits");
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_INSEL, 8'hcc | 8'(s * 17));
         rchk(ADDR_INSEL, 8'(s * 17), "insel");
         v = (s == 2) ? 8'h00 : (s == 3) ? 8'h24 : 8'(8'h09 << s);
         chk(8'(input_route[9:4]), v, "route");
      end
      wr(ADDR_INSEL, 8'h30);
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_STATUS, 8'h90 | 8'(m));
         edge_to(1'b1);
         chk(8'(cmp_irq), 8'(hit(2'(m), 1'b1)), "irq_rise");
         wr(ADDR_STATUS, 8'hb0 | 8'(m));
         chk(8'(cmp_irq), 8'(hit(2'(m), 1'b1)), "irq_keep");
         wr(ADDR_STATUS, 8'h90 | 8'(m));
         chk(8'(cmp_irq), 8'h00, "irq_clear");
         edge_to(1'b0);
         v = 8'h90 | 8'(m) | {2'h0, hit(2'(m), 1'b0), 5'h00};
         rchk(ADDR_STATUS, v, "flag");
         wr(ADDR_STATUS, 8'h90 | 8'(m));
      end
      slow <= 1'b1;
      wr(ADDR_STATUS, 8'hc4);
      edge_to(1'b1);
      rchk(ADDR_STATUS, 8'hcc, "status_out");
      chk(8'({cmp_pin_oe, cmp_pin_out}), 8'h03, "pin");
      chk(8'({comparator_enable, comparator_hyst}), 8'h03, "core_on");
      wr(ADDR_STATUS, 8'h04);
      rchk(ADDR_STATUS, 8'h04, "status_off");
      chk(8'({cmp_pin_oe, cmp_pin_out}), 8'h02, "pin_off");
      wr(ADDR_STATUS, 8'h81);
      edge_to(1'b1);
      wr(ADDR_STATUS, 8'h91);
      @(posedge core_clk);
      low_power_stop_state <= 1'b1;
      edge_to(1'b0);
      chk(8'(wake_irq), 8'h00, "wake_fall");
      rchk(ADDR_STATUS, 8'h99, "status_stop");
      edge_to(1'b1);
      chk(8'(wake_irq), 8'h01, "wake_rise");
      chk(8'(cmp_irq), 8'h00, "irq_stop");
      @(posedge core_clk);
      low_power_stop_state <= 1'b0;
      repeat (6) @(posedge core_clk);
      rchk(ADDR_STATUS, 8'h99, "status_wake");
      chk(8'({wake_irq, cmp_pin_out}), 8'h00, "out_wake");
      test_done();
   end
endmodule
`default_nettype wire
